// file: verilog/pxr_consts.vh
`ifndef PXR_CONSTS_VH
`define PXR_CONSTS_VH
// register indices; byte address is four times the index
`define PXR_IDX_TBCS      8'd22
`define PXR_IDX_CTL1      8'd23
`define PXR_IDX_CTL2      8'd24
`define PXR_IDX_IMASK     8'd25
`define PXR_IDX_ISTAT     8'd26
`define PXR_IDX_EVT_STS   8'd32
`define PXR_IDX_EVT_CLR   8'd33
`define PXR_IDX_EVT_EN    8'd34
// writable bit masks and reset values
`define PXR_WM_TBCS       16'hfe06
`define PXR_RST_TBCS      16'h3200
`define PXR_WM_CTL1       16'h0008
`define PXR_RST_CTL1      16'h0000
`define PXR_WM_CTL2       16'he031
`define PXR_RST_CTL2      16'h0000
`define PXR_WM_IMASK      16'hffbf
`define PXR_RST_IMASK     16'h0000
// index-22 field positions
`define PXR_B_DIS_LINK    15
`define PXR_B_DIS_JAB     14
`define PXR_B_DIS_ECHO    13
`define PXR_B_DIS_SQE     12
`define PXR_F_SQL_HI      11
`define PXR_F_SQL_LO      10
`define PXR_B_STKY_RST    9
`define PXR_B_EOF_ERR     8
`define PXR_B_DISC        7
`define PXR_B_LINK        6
`define PXR_F_CRS_HI      2
`define PXR_F_CRS_LO      1
// index-23 and index-24 field positions
`define PXR_B_FE_LPBK     3
`define PXR_F_EDGE_HI     15
`define PXR_F_EDGE_LO     13
`define PXR_F_JUMBO_HI    5
`define PXR_F_JUMBO_LO    4
`define PXR_B_CBL_LPBK    0
// index-25/26 field positions
`define PXR_B_GIE         15
`define PXR_B_RSVD_INT    6
// carrier-sense selection codes
`define PXR_CRS_RX_TXHD   2'h0
`define PXR_CRS_ANY_HD    2'h1
`define PXR_CRS_RX        2'h2
`define PXR_CRS_RX_HD     2'h3
// maximum packet lengths in bytes
`define PXR_LEN_NORMAL    14'd1518
`define PXR_LEN_JUMBO9K   14'd9000
`define PXR_LEN_JUMBO12K  14'd12000
// event status bit positions
`define PXR_EV_PHY_IRQ    0
`define PXR_EV_EOF_ERR    1
`define PXR_EV_DISC       2
// axi responses
`define PXR_RESP_OKAY     2'h0
`define PXR_RESP_SLVERR   2'h2
`endif

// file: verilog/pxr_axil_slave.v
`timescale 1ns/1ns
`default_nettype none
`include "pxr_consts.vh"
// axi4-lite slave front end: one write and one read at a time
module pxr_axil_slave
(
  input  wire        i_sys_clk,
  input  wire        i_srst,
  input  wire [9:0]  i_s_axi_awaddr,
  input  wire        i_s_axi_awvalid,
  output wire        o_s_axi_awready,
  input  wire [31:0] i_s_axi_wdata,
  input  wire [3:0]  i_s_axi_wstrb,
  input  wire        i_s_axi_wvalid,
  output wire        o_s_axi_wready,
  output wire [1:0]  o_s_axi_bresp,
  output wire        o_s_axi_bvalid,
  input  wire        i_s_axi_bready,
  input  wire [9:0]  i_s_axi_araddr,
  input  wire        i_s_axi_arvalid,
  output wire        o_s_axi_arready,
  output wire [31:0] o_s_axi_rdata,
  output wire [1:0]  o_s_axi_rresp,
  output wire        o_s_axi_rvalid,
  input  wire        i_s_axi_rready,
  output wire        o_wr_en,
  output wire [9:0]  o_wr_addr,
  output wire [31:0] o_wr_data,
  output wire [3:0]  o_wr_strb,
  input  wire        i_wr_err,
  output wire        o_rd_en,
  output wire [9:0]  o_rd_addr,
  input  wire [31:0] i_rd_data,
  input  wire        i_rd_err
);
  reg        aw_got_ff;   // write address held
  reg        w_got_ff;    // write data held
  reg [9:0]  awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0]  wstrb_ff;
  reg        bvalid_ff;
  reg [1:0]  bresp_ff;
  reg        ar_got_ff;   // read address held
  reg [9:0]  araddr_ff;
  reg        rvalid_ff;
  reg [1:0]  rresp_ff;
  reg [31:0] rdata_ff;

  // no new channel item is taken while a response is still owed
  assign o_s_axi_awready = ~aw_got_ff & ~bvalid_ff;
  assign o_s_axi_wready  = ~w_got_ff & ~bvalid_ff;
  assign o_s_axi_arready = ~ar_got_ff & ~rvalid_ff;
  assign o_wr_en   = aw_got_ff & w_got_ff & ~bvalid_ff;
  assign o_rd_en   = ar_got_ff & ~rvalid_ff;
  assign o_wr_addr = awaddr_ff;
  assign o_wr_data = wdata_ff;
  assign o_wr_strb = wstrb_ff;
  assign o_rd_addr = araddr_ff;
  assign o_s_axi_bvalid = bvalid_ff;
  assign o_s_axi_bresp  = bresp_ff;
  assign o_s_axi_rvalid = rvalid_ff;
  assign o_s_axi_rresp  = rresp_ff;
  assign o_s_axi_rdata  = rdata_ff;

  // write side: address and data in either order, then one response
  always @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= 10'h000;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= `PXR_RESP_OKAY;
    end
    else
    begin
      if (i_s_axi_awvalid && o_s_axi_awready)
      begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready)
      begin
        w_got_ff <= 1'b1;
        wdata_ff <= i_s_axi_wdata;
        wstrb_ff <= i_s_axi_wstrb;
      end
      if (o_wr_en)
      begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= i_wr_err ? `PXR_RESP_SLVERR : `PXR_RESP_OKAY;
      end
      else if (bvalid_ff && i_s_axi_bready)
        bvalid_ff <= 1'b0;
    end
  end

  // read side: data is captured on the cycle the register bank is read
  always @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      ar_got_ff <= 1'b0;
      araddr_ff <= 10'h000;
      rvalid_ff <= 1'b0;
      rresp_ff  <= `PXR_RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      if (i_s_axi_arvalid && o_s_axi_arready)
      begin
        ar_got_ff <= 1'b1;
        araddr_ff <= i_s_axi_araddr;
      end
      if (o_rd_en)
      begin
        ar_got_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rdata_ff  <= i_rd_data;
        rresp_ff  <= i_rd_err ? `PXR_RESP_SLVERR : `PXR_RESP_OKAY;
      end
      else if (rvalid_ff && i_s_axi_rready)
        rvalid_ff <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: verilog/pxr_regs.v
// What this block does
// - index 22 bits 15,14 disable link, jabber
// - index 22 bits 13,12 disable echo, sqe
// - bits 11:10 pick squelch threshold level
// - bits 2:1 choose carrier-sense equation
// - index 23 holds only far-end loopback
// - index 24 bits 15:13 edge-rate step
// - index 24 bits 5:4 maximum packet length
// - index 24 bit 0 cable loopback
// - index 25 global enable plus source masks
// - fixed assignment of mask bits to sources
// - masked-off source never shows in status
// - masked conditions stay pending until unmasked
// - status read clears only unmasked pending
// - global enable off forces summary and pin low
// - status at index 26, bit 15 summary
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "pxr_consts.vh"
module pxr_regs
(
  input  wire        i_sys_clk,
  input  wire        i_srst,
  input  wire [9:0]  i_s_axi_awaddr,
  input  wire        i_s_axi_awvalid,
  output wire        o_s_axi_awready,
  input  wire [31:0] i_s_axi_wdata,
  input  wire [3:0]  i_s_axi_wstrb,
  input  wire        i_s_axi_wvalid,
  output wire        o_s_axi_wready,
  output wire [1:0]  o_s_axi_bresp,
  output wire        o_s_axi_bvalid,
  input  wire        i_s_axi_bready,
  input  wire [9:0]  i_s_axi_araddr,
  input  wire        i_s_axi_arvalid,
  output wire        o_s_axi_arready,
  output wire [31:0] o_s_axi_rdata,
  output wire [1:0]  o_s_axi_rresp,
  output wire        o_s_axi_rvalid,
  input  wire        i_s_axi_rready,
  input  wire [14:0] i_int_src,
  input  wire        i_eof_err_evt,
  input  wire        i_disc_evt,
  input  wire        i_tb_link_up,
  input  wire        i_receiving,
  input  wire        i_transmitting,
  input  wire        i_full_duplex_flag,
  output wire        o_dis_link_sm,
  output wire        o_dis_jabber,
  output wire        o_dis_echo,
  output wire        o_dis_sqe,
  output wire [1:0]  o_squelch_sel,
  output wire        o_sticky_rst_en,
  output wire        o_carrier_sense,
  output wire        o_far_end_lpbk,
  output wire [2:0]  o_edge_rate,
  output wire [1:0]  o_jumbo_sel,
  output wire [13:0] o_max_pkt_len,
  output wire        o_cable_lpbk,
  output wire        o_phy_irq,
  output wire        o_irq
);

  // byte lanes 0 and 1 carry the 16-bit register; only writable bits change
  function [15:0] pxr_merge;
    input [15:0] old_val;
    input [31:0] wdata;
    input [3:0]  strb;
    input [15:0] wmask;
    reg   [15:0] lane;
    begin
      lane = {(strb[1] ? wdata[15:8] : old_val[15:8]),
              (strb[0] ? wdata[7:0]  : old_val[7:0])};
      pxr_merge = lane & wmask;
    end
  endfunction

  // byte address to register index
  function [7:0] pxr_idx;
    input [9:0] addr;
    begin
      pxr_idx = addr[9:2];
    end
  endfunction

  // true for every index that answers okay
  function pxr_mapped;
    input [7:0] idx;
    begin
      case (idx)
        `PXR_IDX_TBCS, `PXR_IDX_CTL1, `PXR_IDX_CTL2, `PXR_IDX_IMASK,
        `PXR_IDX_ISTAT, `PXR_IDX_EVT_STS, `PXR_IDX_EVT_CLR,
        `PXR_IDX_EVT_EN: pxr_mapped = 1'b1;
        default:         pxr_mapped = 1'b0;
      endcase
    end
  endfunction

  wire        wr_en;         // one-cycle write strobe from the bus slave
  wire [9:0]  wr_addr;
  wire [31:0] wr_data;
  wire [3:0]  wr_strb;
  wire        rd_en;         // one-cycle read strobe, read side effects fire here
  wire [9:0]  rd_addr;
  reg  [31:0] rd_data;       // combinational read mux
  wire [7:0]  wr_i;
  wire [7:0]  rd_i;

  reg  [15:0] tbcs_ff;       // writable part of index 22
  reg  [15:0] ctl1_ff;       // index 23
  reg  [15:0] ctl2_ff;       // index 24
  reg  [15:0] imask_ff;      // index 25
  reg  [14:0] pend_ff;       // internal pending conditions, one per source
  reg         eof_err_ff;    // sticky end-of-frame error
  reg         disc_ff;       // sticky disconnected flag
  reg         crs_ff;        // carrier sense out
  reg  [13:0] max_len_ff;    // decoded packet length limit
  reg         phy_irq_ff;    // summary as seen last cycle, for edge detect
  reg  [2:0]  evt_sts_ff;    // sticky block events
  reg  [2:0]  evt_en_ff;     // event enables

  reg  [14:0] nxt_pend;
  reg         nxt_eof_err;
  reg         nxt_disc;
  reg         nxt_crs;
  reg  [13:0] nxt_max_len;
  reg  [2:0]  nxt_evt_sts;

  wire [14:0] src_mask;      // per-source masks, reserved bit forced off
  wire [14:0] istat_bits;    // what the status register shows
  wire        summary;
  wire        rd_istat;
  wire        rd_tbcs;
  wire [2:0]  evt_in;

  assign wr_i = pxr_idx(wr_addr);
  assign rd_i = pxr_idx(rd_addr);

  // bus slave: handshakes and response timing live there
  pxr_axil_slave u_axil
  (
    .i_sys_clk       (i_sys_clk),
    .i_srst          (i_srst),
    .i_s_axi_awaddr  (i_s_axi_awaddr),
    .i_s_axi_awvalid (i_s_axi_awvalid),
    .o_s_axi_awready (o_s_axi_awready),
    .i_s_axi_wdata   (i_s_axi_wdata),
    .i_s_axi_wstrb   (i_s_axi_wstrb),
    .i_s_axi_wvalid  (i_s_axi_wvalid),
    .o_s_axi_wready  (o_s_axi_wready),
    .o_s_axi_bresp   (o_s_axi_bresp),
    .o_s_axi_bvalid  (o_s_axi_bvalid),
    .i_s_axi_bready  (i_s_axi_bready),
    .i_s_axi_araddr  (i_s_axi_araddr),
    .i_s_axi_arvalid (i_s_axi_arvalid),
    .o_s_axi_arready (o_s_axi_arready),
    .o_s_axi_rdata   (o_s_axi_rdata),
    .o_s_axi_rresp   (o_s_axi_rresp),
    .o_s_axi_rvalid  (o_s_axi_rvalid),
    .i_s_axi_rready  (i_s_axi_rready),
    .o_wr_en         (wr_en),
    .o_wr_addr       (wr_addr),
    .o_wr_data       (wr_data),
    .o_wr_strb       (wr_strb),
    .i_wr_err        (~pxr_mapped(wr_i)),
    .o_rd_en         (rd_en),
    .o_rd_addr       (rd_addr),
    .i_rd_data       (rd_data),
    .i_rd_err        (~pxr_mapped(rd_i))
  );

  // interrupt view: a masked-off source never reaches the status bits
  assign src_mask   = imask_ff[14:0] & ~(15'h0001 << `PXR_B_RSVD_INT);
  assign istat_bits = pend_ff & src_mask;
  assign summary    = imask_ff[`PXR_B_GIE] & (|istat_bits);
  assign rd_istat   = rd_en & (rd_i == `PXR_IDX_ISTAT);
  assign rd_tbcs    = rd_en & (rd_i == `PXR_IDX_TBCS);

  // control field outputs straight from the register flops; carrier sense and length limit come from their own decoded flops
  assign o_dis_link_sm   = tbcs_ff[`PXR_B_DIS_LINK];
  assign o_dis_jabber    = tbcs_ff[`PXR_B_DIS_JAB];
  assign o_dis_echo      = tbcs_ff[`PXR_B_DIS_ECHO];
  assign o_dis_sqe       = tbcs_ff[`PXR_B_DIS_SQE];
  assign o_squelch_sel   = tbcs_ff[`PXR_F_SQL_HI:`PXR_F_SQL_LO];
  assign o_sticky_rst_en = tbcs_ff[`PXR_B_STKY_RST];
  assign o_carrier_sense = crs_ff;
  assign o_far_end_lpbk  = ctl1_ff[`PXR_B_FE_LPBK];
  assign o_edge_rate     = ctl2_ff[`PXR_F_EDGE_HI:`PXR_F_EDGE_LO];
  assign o_jumbo_sel     = ctl2_ff[`PXR_F_JUMBO_HI:`PXR_F_JUMBO_LO];
  assign o_max_pkt_len   = max_len_ff;
  assign o_cable_lpbk    = ctl2_ff[`PXR_B_CBL_LPBK];
  // pin follows the summary bit, so the global enable holds it low too
  assign o_phy_irq       = summary;
  assign o_irq           = |(evt_sts_ff & evt_en_ff);

  // block events: summary rising edge, eof error, disconnect
  assign evt_in = {i_disc_evt, i_eof_err_evt, summary & ~phy_irq_ff};

  // read mux; reserved bits come back as zero
  always @*
  begin
    rd_data = 32'h0000_0000;
    case (rd_i)
      `PXR_IDX_TBCS:
      begin
        rd_data[15:0] = tbcs_ff & `PXR_WM_TBCS;
        rd_data[`PXR_B_EOF_ERR] = eof_err_ff;
        rd_data[`PXR_B_DISC]    = disc_ff;
        rd_data[`PXR_B_LINK]    = i_tb_link_up;
      end
      `PXR_IDX_CTL1:    rd_data[15:0] = ctl1_ff & `PXR_WM_CTL1;
      `PXR_IDX_CTL2:    rd_data[15:0] = ctl2_ff & `PXR_WM_CTL2;
      `PXR_IDX_IMASK:   rd_data[15:0] = imask_ff & `PXR_WM_IMASK;
      `PXR_IDX_ISTAT:   rd_data[15:0] = {summary, istat_bits};
      `PXR_IDX_EVT_STS: rd_data[2:0]  = evt_sts_ff;
      `PXR_IDX_EVT_EN:  rd_data[2:0]  = evt_en_ff;
      default:          rd_data = 32'h0000_0000;
    endcase
  end

  // pending set and clear; a new condition in the clearing cycle survives
  always @*
  begin
    nxt_pend = pend_ff;
    if (rd_istat)
      nxt_pend = pend_ff & ~src_mask;
    nxt_pend = nxt_pend | (i_int_src & ~(15'h0001 << `PXR_B_RSVD_INT));
  end

  // read-clear sticky flags of index 22, set wins over the read
  always @*
  begin
    nxt_eof_err = (eof_err_ff & ~rd_tbcs) | i_eof_err_evt;
    nxt_disc    = (disc_ff & ~rd_tbcs) | i_disc_evt;
  end

  // carrier-sense equation selected by the control field
  always @*
  begin
    case (tbcs_ff[`PXR_F_CRS_HI:`PXR_F_CRS_LO])
      `PXR_CRS_RX_TXHD: nxt_crs = i_receiving | (i_transmitting & ~i_full_duplex_flag);
      `PXR_CRS_ANY_HD:  nxt_crs = (i_receiving | i_transmitting) & ~i_full_duplex_flag;
      `PXR_CRS_RX:      nxt_crs = i_receiving;
      `PXR_CRS_RX_HD:   nxt_crs = i_receiving & ~i_full_duplex_flag;
      default:          nxt_crs = i_receiving;
    endcase
  end

  // packet length limit; the reserved code falls back to normal length
  always @*
  begin
    case (ctl2_ff[`PXR_F_JUMBO_HI:`PXR_F_JUMBO_LO])
      2'h1:    nxt_max_len = `PXR_LEN_JUMBO9K;
      2'h2:    nxt_max_len = `PXR_LEN_JUMBO12K;
      default: nxt_max_len = `PXR_LEN_NORMAL;
    endcase
  end

  // event status: write-one-to-clear, a set in the same cycle wins
  always @*
  begin
    nxt_evt_sts = evt_sts_ff;
    if (wr_en && (wr_i == `PXR_IDX_EVT_CLR) && wr_strb[0])
      nxt_evt_sts = evt_sts_ff & ~wr_data[2:0];
    nxt_evt_sts = nxt_evt_sts | evt_in;
  end

  // software-written control registers
  always @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      tbcs_ff   <= `PXR_RST_TBCS;
      ctl1_ff   <= `PXR_RST_CTL1;
      ctl2_ff   <= `PXR_RST_CTL2;
      imask_ff  <= `PXR_RST_IMASK;
      evt_en_ff <= 3'h0;
    end
    else if (wr_en)
    begin
      // writes to read-only indices are accepted and dropped
      case (wr_i)
        `PXR_IDX_TBCS:  tbcs_ff  <= pxr_merge(tbcs_ff, wr_data, wr_strb, `PXR_WM_TBCS);
        `PXR_IDX_CTL1:  ctl1_ff  <= pxr_merge(ctl1_ff, wr_data, wr_strb, `PXR_WM_CTL1);
        `PXR_IDX_CTL2:  ctl2_ff  <= pxr_merge(ctl2_ff, wr_data, wr_strb, `PXR_WM_CTL2);
        `PXR_IDX_IMASK: imask_ff <= pxr_merge(imask_ff, wr_data, wr_strb, `PXR_WM_IMASK);
        `PXR_IDX_EVT_EN:
        begin
          if (wr_strb[0])
            evt_en_ff <= wr_data[2:0];
        end
        default:        evt_en_ff <= evt_en_ff;
      endcase
    end
  end

  // hardware-updated state
  always @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      pend_ff    <= 15'h0000;
      eof_err_ff <= 1'b0;
      disc_ff    <= 1'b0;
      crs_ff     <= 1'b0;
      max_len_ff <= `PXR_LEN_NORMAL;
      phy_irq_ff <= 1'b0;
      evt_sts_ff <= 3'h0;
    end
    else
    begin
      pend_ff    <= nxt_pend;
      eof_err_ff <= nxt_eof_err;
      disc_ff    <= nxt_disc;
      crs_ff     <= nxt_crs;
      max_len_ff <= nxt_max_len;
      phy_irq_ff <= summary;
      evt_sts_ff <= nxt_evt_sts;
    end
  end

endmodule
`default_nettype wire

// file: dv/pxr_regs_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// bus timing and pin relations at the block's ports
module pxr_regs_monitor
(
  input wire        i_sys_clk,
  input wire        i_srst,
  input wire [9:0]  i_s_axi_awaddr,
  input wire        i_s_axi_awvalid,
  input wire        o_s_axi_awready,
  input wire [31:0] i_s_axi_wdata,
  input wire        i_s_axi_wvalid,
  input wire        o_s_axi_wready,
  input wire        o_s_axi_bvalid,
  input wire        i_s_axi_bready,
  input wire        i_s_axi_arvalid,
  input wire        o_s_axi_arready,
  input wire [31:0] o_s_axi_rdata,
  input wire        o_s_axi_rvalid,
  input wire        i_s_axi_rready,
  input wire        i_receiving,
  input wire        i_transmitting,
  input wire        i_full_duplex_flag,
  input wire        o_carrier_sense,
  input wire [1:0]  o_jumbo_sel,
  input wire [13:0] o_max_pkt_len,
  input wire        o_phy_irq
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  wire  wr_take = i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  logic gie_ff;  // leads the device by a cycle
  // shadow of the global enable bit
  always @(posedge i_sys_clk)
  begin
    if (i_srst)
      gie_ff <= 1'b0;
    else if (wr_take && i_s_axi_awaddr[9:2] == 8'd25)
      gie_ff <= i_s_axi_wdata[15];
  end
  sequence s_wr_take;
    wr_take;
  endsequence
  sequence s_rd_take;
    i_s_axi_arvalid && o_s_axi_arready;
  endsequence
  AST_WR_LAT: assert property (s_wr_take |=> !o_s_axi_bvalid ##[1:2] o_s_axi_bvalid)
    else $error("write answer not on time");
  AST_RD_LAT: assert property (s_rd_take |=> !o_s_axi_rvalid ##[1:2] o_s_axi_rvalid)
    else $error("read answer not on time");
  AST_B_HOLD: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid)
    else $error("write answer dropped early");
  AST_R_HOLD: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read answer changed early");
  AST_AW_REFUSE: assert property (o_s_axi_bvalid |-> !o_s_axi_awready)
    else $error("address taken with answer owed");
  AST_R_UPPER: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  AST_CRS_ON: assert property ($past(i_receiving) && !$past(i_full_duplex_flag) |-> o_carrier_sense)
    else $error("carrier sense missing");
  AST_CRS_OFF: assert property (!$past(i_receiving) && !$past(i_transmitting) |-> !o_carrier_sense)
    else $error("carrier sense while idle");
  AST_MAX_LEN: assert property (o_max_pkt_len == ($past(o_jumbo_sel) == 2'h1 ? 14'd9000 :
    $past(o_jumbo_sel) == 2'h2 ? 14'd12000 : 14'd1518)) else $error("packet length wrong");
  AST_GIE_PIN: assert property (o_phy_irq |-> gie_ff || $past(gie_ff) || $past(gie_ff, 2))
    else $error("pin without global enable");
endmodule
bind pxr_regs pxr_regs_monitor u_mon (.*);
`default_nettype wire

// file: dv/pxr_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// management host: axi4-lite master
module pxr_host_model
(
  input  wire         i_sys_clk,
  output logic [9:0]  i_s_axi_awaddr,
  output logic        i_s_axi_awvalid,
  input  wire         o_s_axi_awready,
  output logic [31:0] i_s_axi_wdata,
  output logic [3:0]  i_s_axi_wstrb,
  output logic        i_s_axi_wvalid,
  input  wire         o_s_axi_wready,
  input  wire  [1:0]  o_s_axi_bresp,
  input  wire         o_s_axi_bvalid,
  output logic        i_s_axi_bready,
  output logic [9:0]  i_s_axi_araddr,
  output logic        i_s_axi_arvalid,
  input  wire         o_s_axi_arready,
  input  wire  [31:0] o_s_axi_rdata,
  input  wire  [1:0]  o_s_axi_rresp,
  input  wire         o_s_axi_rvalid,
  output logic        i_s_axi_rready
);
  logic slow;  // when set, ready rises after the answer
  // idle bus at time zero
  initial
  begin
    {i_s_axi_awaddr, i_s_axi_awvalid, i_s_axi_wdata, i_s_axi_wvalid, i_s_axi_bready} = '0;
    {i_s_axi_araddr, i_s_axi_arvalid, i_s_axi_rready, slow} = '0;
    i_s_axi_wstrb = 4'hf;
  end
  // write one word; released payload is inverted against stale reuse
  task automatic wr(input logic [7:0] idx, input logic [15:0] d, output logic [1:0] rsp);
    @(posedge i_sys_clk);
    i_s_axi_awaddr <= {idx, 2'b00};
    i_s_axi_wdata <= {16'h0000, d};
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= !slow;
    fork
      begin
        do @(posedge i_sys_clk); while (!o_s_axi_awready);
        i_s_axi_awvalid <= 1'b0;
        i_s_axi_awaddr <= ~i_s_axi_awaddr;
      end
      begin
        do @(posedge i_sys_clk); while (!o_s_axi_wready);
        i_s_axi_wvalid <= 1'b0;
        i_s_axi_wdata <= ~i_s_axi_wdata;
      end
    join
    do @(posedge i_sys_clk); while (!o_s_axi_bvalid);
    if (slow)
    begin
      i_s_axi_bready <= 1'b1;
      @(posedge i_sys_clk);
    end
    rsp = o_s_axi_bresp;
    i_s_axi_bready <= 1'b0;
  endtask
  // read one word
  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] rsp);
    @(posedge i_sys_clk);
    i_s_axi_araddr <= {idx, 2'b00};
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= !slow;
    do @(posedge i_sys_clk); while (!o_s_axi_arready);
    i_s_axi_arvalid <= 1'b0;
    i_s_axi_araddr <= ~i_s_axi_araddr;
    do @(posedge i_sys_clk); while (!o_s_axi_rvalid);
    if (slow)
    begin
      i_s_axi_rready <= 1'b1;
      @(posedge i_sys_clk);
    end
    d = o_s_axi_rdata;
    rsp = o_s_axi_rresp;
    i_s_axi_rready <= 1'b0;
  endtask
  // interrupt bring-up; st is the drain read
  task automatic en_irq(input logic [14:0] m, output logic [31:0] st);
    logic [1:0] r;
    wr(8'd25, {1'b0, m}, r);
    rd(8'd26, st, r);
    wr(8'd25, {1'b1, m}, r);
  endtask
endmodule
`default_nettype wire

// file: dv/pxr_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module pxr_regs_tb;
  typedef struct {logic [7:0] idx; logic [15:0] wd; logic [31:0] rd; logic [1:0] rsp; logic [13:0] outs;} pxr_row_t;
  logic        i_sys_clk, i_srst, i_eof_err_evt, i_disc_evt, i_tb_link_up;
  logic        i_receiving, i_transmitting, i_full_duplex_flag;
  logic [14:0] i_int_src;
  wire  [9:0]  i_s_axi_awaddr, i_s_axi_araddr;
  wire  [31:0] i_s_axi_wdata, o_s_axi_rdata;
  wire  [3:0]  i_s_axi_wstrb;
  wire  [1:0]  o_s_axi_bresp, o_s_axi_rresp, o_squelch_sel, o_jumbo_sel;
  wire  [2:0]  o_edge_rate;
  wire  [13:0] o_max_pkt_len;
  wire         i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready;
  wire         o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  wire         o_dis_link_sm, o_dis_jabber, o_dis_echo, o_dis_sqe, o_sticky_rst_en, o_carrier_sense;
  wire         o_far_end_lpbk, o_cable_lpbk, o_phy_irq, o_irq;
  wire  [13:0] outs = {o_dis_link_sm, o_dis_jabber, o_dis_echo, o_dis_sqe, o_squelch_sel, o_sticky_rst_en,
                       o_far_end_lpbk, o_edge_rate, o_jumbo_sel, o_cable_lpbk};
  int          error_cnt = 0;
  int          checks = 0;
  int          cyc = 0;
  logic [31:0] rdv;
  logic [1:0]  rsp;
  // index, written, read back, response, field pins
  pxr_row_t    rows [10] = '{'{8'd22, 16'hffff, 32'hfe46, 2'h0, 14'h3f80}, '{8'd22, 16'h0000, 32'h0040, 2'h0, 14'h0},
                           '{8'd23, 16'hffff, 32'h0008, 2'h0, 14'h0040}, '{8'd23, 16'h0000, 32'h0, 2'h0, 14'h0},
                           '{8'd24, 16'hffff, 32'he031, 2'h0, 14'h003f}, '{8'd24, 16'h0000, 32'h0, 2'h0, 14'h0},
                           '{8'd25, 16'hffff, 32'hffbf, 2'h0, 14'h0}, '{8'd25, 16'h0000, 32'h0, 2'h0, 14'h0},
                           '{8'd26, 16'hffff, 32'h0, 2'h0, 14'h0}, '{8'd16, 16'hffff, 32'h0, 2'h2, 14'h0}};
  pxr_regs       uut (.*);
  pxr_host_model u_host (.*);
  initial
  begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  // one-cycle condition pulses
  task automatic pulse(input logic [14:0] s, input logic e, input logic d);
    @(posedge i_sys_clk);
    {i_int_src, i_eof_err_evt, i_disc_evt} <= {s, e, d};
    @(posedge i_sys_clk);
    {i_int_src, i_eof_err_evt, i_disc_evt} <= '0;
  endtask
  // expected carrier sense; v = {rx, tx, full duplex}
  function automatic logic crs_exp(input logic [1:0] m, input logic [2:0] v);
    case (m)
      2'h0: return v[2] | (v[1] & ~v[0]);
      2'h1: return (v[2] | v[1]) & ~v[0];
      2'h2: return v[2];
      default: return v[2] & ~v[0];
    endcase
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // hang guard, far above a normal run
  always @(posedge i_sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      error_cnt++;
      $display("[FAIL] %0t run did not finish", $time);
      complete_run();
    end
  end
  initial
  begin
    {i_int_src, i_eof_err_evt, i_disc_evt, i_receiving, i_transmitting, i_full_duplex_flag} = '0;
    {i_srst, i_tb_link_up} = 2'h3;
    wait_clk(12);
    i_srst <= 1'b0;
    foreach (rows[k])
    begin
      u_host.wr(rows[k].idx, rows[k].wd, rsp);
      chk(rsp, rows[k].rsp, "write response");
      u_host.rd(rows[k].idx, rdv, rsp);
      chk(rdv, rows[k].rd, "readback");
      chk(rsp, rows[k].rsp, "read response");
      chk(outs, rows[k].outs, "field pins");
    end
    $display("table test done");
    for (int c = 0; c < 8; c++)
    begin
      u_host.wr(8'd24, {c[2:0], 7'h00, c[1:0], 4'h0}, rsp);
      wait_clk(2);
      chk({o_edge_rate, o_jumbo_sel}, {c[2:0], c[1:0]}, "edge and jumbo");
    end
    for (int c = 0; c < 4; c++)
    begin
      u_host.wr(8'd22, {4'h3, c[1:0], 7'h00, c[1:0], 1'b0}, rsp);
      for (int v = 0; v < 8; v++)
      begin
        {i_receiving, i_transmitting, i_full_duplex_flag} <= v[2:0];
        wait_clk(2);
        chk(o_carrier_sense, crs_exp(c[1:0], v[2:0]), "carrier sense");
      end
      chk(o_squelch_sel, c[1:0], "squelch code");
    end
    {i_receiving, i_transmitting, i_full_duplex_flag} <= 3'h0;
    $display("field code test done");
    u_host.slow = 1'b1;
    pulse(15'h2001, 1'b0, 1'b0);
    u_host.rd(8'd26, rdv, rsp);
    chk(rdv, 32'h0, "masked source hidden");
    u_host.en_irq(15'h2000, rdv);
    chk(rdv, 32'h2000, "pending shown");
    u_host.wr(8'd34, 16'h0001, rsp);
    wait_clk(2);
    chk(o_phy_irq, 1'b0, "drained before enable");
    pulse(15'h2000, 1'b0, 1'b0);
    wait_clk(3);
    chk({o_phy_irq, o_irq}, 2'h3, "irqs raised");
    u_host.rd(8'd26, rdv, rsp);
    chk(rdv, 32'ha000, "summary and source");
    u_host.rd(8'd26, rdv, rsp);
    chk(rdv, 32'h0, "cleared by read");
    u_host.wr(8'd25, 16'h0001, rsp);
    chk(o_phy_irq, 1'b0, "no pin without enable");
    u_host.rd(8'd26, rdv, rsp);
    chk(rdv, 32'h0001, "masked pending kept");
    pulse(15'h0, 1'b1, 1'b1);
    u_host.rd(8'd22, rdv, rsp);
    chk(rdv[8:7], 2'h3, "sticky bits set");
    u_host.rd(8'd22, rdv, rsp);
    chk(rdv[8:7], 2'h0, "sticky bits cleared");
    u_host.rd(8'd32, rdv, rsp);
    chk(rdv, 32'h7, "event status");
    u_host.wr(8'd34, 16'h0000, rsp);
    wait_clk(2);
    chk(o_irq, 1'b0, "event irq masked");
    u_host.wr(8'd33, 16'h0007, rsp);
    u_host.rd(8'd32, rdv, rsp);
    chk(rdv, 32'h0, "event status cleared");
    u_host.slow = 1'b0;
    $display("interrupt test done");
    i_tb_link_up <= 1'b0;
    i_srst <= 1'b1;
    wait_clk(12);
    i_srst <= 1'b0;
    for (int k = 0; k < 5; k++)
    begin
      u_host.rd(8'd22 + k[7:0], rdv, rsp);
      chk(rdv, k == 0 ? 32'h3200 : 32'h0, "reset value");
    end
    chk(o_max_pkt_len, 14'd1518, "reset length");
    $display("reset test done");
    complete_run();
  end
endmodule
`default_nettype wire
